// ==== rtl/asc_seq_ctrl.sv ====
// Purpose: Four-conversion sequencer with control/status and result slots.
// Assumes: Stop, wait and comparator inputs come from logic on the bus clock.
// Notes:   Registers sit on AXI4-Lite; one write and one read at a time.
// Contract
// - Single channel, no repeat: convert the chosen input four times into slots one..four.
// - Group mode, no repeat: convert each group channel once, first to slot one.
// - Without repeat, halt after the fourth conversion until the next control write with byte lane zero enabled.
// - Repeat in single mode: keep converting, results wrap cyclically through the slots.
// - Repeat in group mode: cycle the group, each result replacing its slot.
// - Stop or wait suspends the current channel; resume resamples and continues.
// - Control bit 7 is read-only status, bit 6 reads zero, others read/write.
// - A control write with byte lane zero enabled starts a sequence, abandoning one that is running.
// - Done flag sets once all four slots hold results of this sequence.
// - A control write with byte lane zero enabled clears the done flag as the new sequence begins.
// - In repeat mode the flag sets after the first four, slots keep updating.
// - Single mode uses all four select bits to choose the input.
// - Group mode ignores the two low select bits; the upper two pick the group.
// - Codes 0-7 external inputs, 10XX reserved, 1100/1101/1110 references, 1111 reserved.
// - In group mode low select bits 00..11 map to slots one..four.
// - A four-conversion sequence takes 128 bus cycles.
// - The sequence begins one bus cycle after the control write.
// - Result slots are read-only; writes leave them unchanged.
// - Each conversion resolves eight bits MSB first, then stores into its slot.
`timescale 1ns/1ps
module asc_seq_ctrl (
	input  wire logic              i_core_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_ce,
	input  wire asc_pkg::asc_axi_req_s i_axi,
	output asc_pkg::asc_axi_rsp_s  o_axi,
	input  wire logic              i_stop,
	input  wire logic              i_wait,
	input  wire logic              i_cmp_hi,
	output asc_pkg::asc_ana_s      o_ana
);
	import asc_pkg::*;

	typedef enum logic {ASC_IDLE, ASC_RUN} asc_state_e;
	typedef logic [AXI_AW-WORD_LSB-1:0] asc_word_t;

	localparam asc_word_t WI_CTRL  = OFS_CTRL[AXI_AW-1:WORD_LSB];
	localparam asc_word_t WI_SLOT1 = OFS_SLOT1[AXI_AW-1:WORD_LSB];
	localparam asc_word_t WI_SLOT4 = OFS_SLOT4[AXI_AW-1:WORD_LSB];
	localparam logic [SLOT_W-1:0] LAST_SLOT = SLOT_W'(SLOTS - 1);

	if (SEQ_CYCLES != SLOTS * CONV_CYCLES || SLOTS != 2 ** SLOT_W) begin : g_bad_seq
		$error("asc_seq_ctrl: sequence length does not match conversion length");
	end

	function automatic asc_word_t word_of(input logic [AXI_AW-1:0] a);
		return a[AXI_AW-1:WORD_LSB];
	endfunction

	function automatic logic [SLOT_W-1:0] slot_of(input asc_word_t w);
		return SLOT_W'(w - WI_SLOT1);
	endfunction

	function automatic logic [CHAN_W-1:0] chan_of(input asc_ctrl_s c,
			input logic [SLOT_W-1:0] i);
		return c.group_mode_select ? {c.chan[CHAN_W-1:SLOT_W], i} : c.chan;
	endfunction

	function automatic logic code_reserved(input logic [CHAN_W-1:0] c);
		return c[CHAN_W-1:SLOT_W] == CODE_RSV_GRP || c == CODE_RSV_TOP;
	endfunction

	// Bus slave state.
	logic              aw_ok_r;
	logic              aw_ok_nxt;
	logic [AXI_AW-1:0] awaddr_r;
	logic [AXI_AW-1:0] awaddr_nxt;
	logic              w_ok_r;
	logic              w_ok_nxt;
	logic [AXI_DW-1:0] wdata_r;
	logic [AXI_DW-1:0] wdata_nxt;
	logic              wstrb0_r;
	logic              wstrb0_nxt;
	asc_axi_rsp_s      rsp_r;
	asc_axi_rsp_s      rsp_nxt;
	logic              wr_fire;
	logic              ctrl_wr;

	// Sequencer state.
	asc_state_e        state_r;
	asc_state_e        state_nxt;
	asc_ctrl_s         ctrl_r;
	asc_ctrl_s         ctrl_nxt;
	logic              flag_r;
	logic              flag_nxt;
	logic              pend_r;
	logic              pend_nxt;
	logic [SLOT_W-1:0] idx_r;
	logic [SLOT_W-1:0] idx_nxt;
	logic [CHAN_W-1:0] mux_r;
	logic [CHAN_W-1:0] mux_nxt;
	logic              mux_ok_r;
	logic              mux_ok_nxt;
	logic [RES_W-1:0]  slot_r [SLOTS];
	logic [RES_W-1:0]  slot_nxt [SLOTS];
	logic              start_conv;
	logic              conv_done;
	logic              conv_sample;
	logic [RES_W-1:0]  conv_dac;

	always_comb begin
		asc_word_t rw;
		rw = word_of(i_axi.araddr);
		aw_ok_nxt = aw_ok_r;
		awaddr_nxt = awaddr_r;
		w_ok_nxt = w_ok_r;
		wdata_nxt = wdata_r;
		wstrb0_nxt = wstrb0_r;
		rsp_nxt = rsp_r;
		wr_fire = aw_ok_r && w_ok_r;
		ctrl_wr = wr_fire && word_of(awaddr_r) == WI_CTRL && wstrb0_r;
		if (i_axi.awvalid && rsp_r.awready) begin
			aw_ok_nxt = 1'b1;
			awaddr_nxt = i_axi.awaddr;
		end
		if (i_axi.wvalid && rsp_r.wready) begin
			w_ok_nxt = 1'b1;
			wdata_nxt = i_axi.wdata;
			wstrb0_nxt = i_axi.wstrb[STRB_CTRL];
		end
		if (rsp_r.bvalid && i_axi.bready) begin
			rsp_nxt.bvalid = 1'b0;
		end
		if (wr_fire) begin
			// Result slots accept the write and keep their contents.
			aw_ok_nxt = 1'b0;
			w_ok_nxt = 1'b0;
			rsp_nxt.bvalid = 1'b1;
			rsp_nxt.bresp = word_of(awaddr_r) <= WI_SLOT4 ? RESP_OKAY : RESP_SLVERR;
		end
		if (rsp_r.rvalid && i_axi.rready) begin
			rsp_nxt.rvalid = 1'b0;
		end
		if (i_axi.arvalid && rsp_r.arready) begin
			rsp_nxt.rvalid = 1'b1;
			rsp_nxt.rdata = '0;
			rsp_nxt.rresp = RESP_OKAY;
			if (rw == WI_CTRL) begin
				rsp_nxt.rdata[BIT_FLAG] = flag_r;
				rsp_nxt.rdata[BIT_ZERO] = 1'b0;
				rsp_nxt.rdata[BIT_SCAN] = ctrl_r.scan;
				rsp_nxt.rdata[BIT_GROUP_MODE_SELECT] = ctrl_r.group_mode_select;
				rsp_nxt.rdata[CHAN_LSB +: CHAN_W] = ctrl_r.chan;
			end else if (rw <= WI_SLOT4) begin
				rsp_nxt.rdata[RES_W-1:0] = slot_r[slot_of(rw)];
			end else begin
				rsp_nxt.rresp = RESP_SLVERR;
			end
		end
		rsp_nxt.awready = !aw_ok_nxt && !rsp_nxt.bvalid;
		rsp_nxt.wready = !w_ok_nxt && !rsp_nxt.bvalid;
		rsp_nxt.arready = !rsp_nxt.rvalid;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aw_ok_r <= 1'b0;
			awaddr_r <= '0;
			w_ok_r <= 1'b0;
			wdata_r <= '0;
			wstrb0_r <= 1'b0;
			rsp_r <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
		end else if (i_ce) begin
			aw_ok_r <= aw_ok_nxt;
			awaddr_r <= awaddr_nxt;
			w_ok_r <= w_ok_nxt;
			wdata_r <= wdata_nxt;
			wstrb0_r <= wstrb0_nxt;
			rsp_r <= rsp_nxt;
		end
	end

	always_comb begin
		state_nxt = state_r;
		ctrl_nxt = ctrl_r;
		flag_nxt = flag_r;
		pend_nxt = pend_r;
		idx_nxt = idx_r;
		mux_nxt = mux_r;
		mux_ok_nxt = mux_ok_r;
		slot_nxt = slot_r;
		start_conv = 1'b0;
		if (ctrl_wr) begin
			// A result landing in this cycle belongs to the abandoned sequence,
			// so the clear wins over it and the store is dropped.
			ctrl_nxt.scan = wdata_r[BIT_SCAN];
			ctrl_nxt.group_mode_select = wdata_r[BIT_GROUP_MODE_SELECT];
			ctrl_nxt.chan = wdata_r[CHAN_LSB +: CHAN_W];
			flag_nxt = 1'b0;
			pend_nxt = 1'b1;
			state_nxt = ASC_IDLE;
		end else if (pend_r) begin
			pend_nxt = 1'b0;
			start_conv = 1'b1;
			idx_nxt = '0;
			state_nxt = ASC_RUN;
		end else begin
			case (state_r)
				ASC_RUN: begin
					if (conv_done) begin
						slot_nxt[idx_r] = conv_dac;
						if (idx_r == LAST_SLOT) begin
							flag_nxt = 1'b1;
						end
						if (idx_r == LAST_SLOT && !ctrl_r.scan) begin
							state_nxt = ASC_IDLE;
						end else begin
							start_conv = 1'b1;
							idx_nxt = idx_r + SLOT_W'(1);
						end
					end
				end
				ASC_IDLE: begin
					state_nxt = ASC_IDLE;
				end
				default: begin
					state_nxt = ASC_IDLE;
				end
			endcase
		end
		if (start_conv) begin
			mux_nxt = chan_of(ctrl_nxt, idx_nxt);
			// Reserved codes convert with normal timing; the result is unspecified.
			mux_ok_nxt = !code_reserved(mux_nxt);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r <= ASC_IDLE;
			ctrl_r <= CTRL_RST;
			flag_r <= 1'b0;
			pend_r <= 1'b0;
			idx_r <= '0;
			mux_r <= '0;
			mux_ok_r <= 1'b0;
			slot_r <= '{default: '0};
		end else if (i_ce) begin
			state_r <= state_nxt;
			ctrl_r <= ctrl_nxt;
			flag_r <= flag_nxt;
			pend_r <= pend_nxt;
			idx_r <= idx_nxt;
			mux_r <= mux_nxt;
			mux_ok_r <= mux_ok_nxt;
			slot_r <= slot_nxt;
		end
	end

	asc_sar #(
		.W (RES_W)
	) u_sar (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_ce       (i_ce),
		.i_start    (start_conv),
		.i_hold     (i_stop || i_wait),
		.i_cmp_hi   (i_cmp_hi),
		.o_sample   (conv_sample),
		.o_dac      (conv_dac),
		.o_done     (conv_done)
	);

	assign o_axi = rsp_r;
	assign o_ana = '{sample: conv_sample, mux_sel: mux_r, mux_ok: mux_ok_r, dac: conv_dac};

	a_restart_begin: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		ctrl_wr && i_ce ##1 i_ce |=> o_ana.sample && state_r == ASC_RUN && idx_r == '0)
		else $error("sequence did not begin one cycle after the control write");
	a_flag_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		ctrl_wr && i_ce |=> !flag_r && pend_r)
		else $error("control write did not clear the done flag");
	a_flag_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		state_r == ASC_RUN && conv_done && idx_r == LAST_SLOT && !ctrl_wr && !pend_r && i_ce
		|=> flag_r)
		else $error("done flag not set after the fourth result");
	a_single_chan: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		start_conv && !ctrl_r.group_mode_select && i_ce |=> o_ana.mux_sel == $past(ctrl_r.chan))
		else $error("single mode did not select the full channel code");
	a_group_chan: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		start_conv && ctrl_r.group_mode_select && i_ce
		|=> o_ana.mux_sel == {$past(ctrl_r.chan[CHAN_W-1:SLOT_W]), idx_r})
		else $error("group mode channel does not follow the slot index");
	a_halt_idle: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		state_r == ASC_RUN && conv_done && idx_r == LAST_SLOT && !ctrl_r.scan
		&& !ctrl_wr && !pend_r && i_ce ##1 (!ctrl_wr && !pend_r && i_ce)[*3]
		|=> state_r == ASC_IDLE && !start_conv)
		else $error("sequence did not halt after four conversions");
	a_scan_wrap: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		state_r == ASC_RUN && conv_done && ctrl_r.scan && !ctrl_wr && !pend_r && i_ce
		|=> state_r == ASC_RUN && idx_r == $past(idx_r) + SLOT_W'(1) && o_ana.sample)
		else $error("repeat mode did not move on to the next slot");
	a_slot_store: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		state_r == ASC_RUN && conv_done && !ctrl_wr && !pend_r && i_ce
		|=> slot_r[$past(idx_r)] == $past(conv_dac))
		else $error("finished conversion not stored in its slot");
	a_ctrl_read: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_axi.arvalid && rsp_r.arready && word_of(i_axi.araddr) == WI_CTRL && i_ce
		|=> o_axi.rvalid && !o_axi.rdata[BIT_ZERO] && o_axi.rdata[BIT_FLAG] == $past(flag_r))
		else $error("control read shows wrong flag or a nonzero bit 6");
endmodule // asc_seq_ctrl

// ==== rtl/asc_pkg.sv ====
// Purpose: Shared constants and carriers for the converter sequencing block.
// Assumes: One bus clock; registers reached over AXI4-Lite with 32-bit data.
// Notes:   Each figure appears here once; the logic uses the names only.
package asc_pkg;
	localparam int RES_W         = 8;
	localparam int CHAN_W        = 4;
	localparam int SLOTS         = 4;
	localparam int SLOT_W        = 2;
	localparam int SAMPLE_CYCLES = 12;
	localparam int BIT_CYCLES    = 2;
	localparam int CONV_CYCLES   = 32;
	localparam int CNT_W         = 5;
	localparam int SEQ_TIME_US   = 64;
	localparam int REF_BUS_MHZ   = 2;
	localparam int SEQ_CYCLES    = SEQ_TIME_US * REF_BUS_MHZ;
	localparam int AXI_AW        = 8;
	localparam int AXI_DW        = 32;
	localparam int WORD_LSB      = 2;

	// Byte offsets of the register words.
	localparam logic [AXI_AW-1:0] OFS_CTRL  = 8'h00;
	localparam logic [AXI_AW-1:0] OFS_SLOT1 = 8'h04;
	localparam logic [AXI_AW-1:0] OFS_SLOT4 = 8'h10;

	// Control/status field positions.
	localparam int BIT_FLAG = 7;
	localparam int BIT_ZERO = 6;
	localparam int BIT_SCAN = 5;
	localparam int BIT_GROUP_MODE_SELECT = 4;
	localparam int CHAN_LSB = 0;
	localparam int STRB_CTRL = 0;

	// Channel-select codes outside the eight external inputs.
	localparam logic [1:0]        CODE_RSV_GRP  = 2'h2;
	localparam logic [CHAN_W-1:0] CODE_HIGH_REF = 4'hc;
	localparam logic [CHAN_W-1:0] CODE_LOW_REF  = 4'hd;
	localparam logic [CHAN_W-1:0] CODE_HALF_REF = 4'he;
	localparam logic [CHAN_W-1:0] CODE_RSV_TOP  = 4'hf;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic              awvalid;
		logic [AXI_AW-1:0] awaddr;
		logic              wvalid;
		logic [AXI_DW-1:0] wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [AXI_AW-1:0] araddr;
		logic              rready;
	} asc_axi_req_s;

	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [AXI_DW-1:0] rdata;
		logic [1:0]        rresp;
	} asc_axi_rsp_s;

	typedef struct packed {
		logic              sample;
		logic [CHAN_W-1:0] mux_sel;
		logic              mux_ok;
		logic [RES_W-1:0]  dac;
	} asc_ana_s;

	typedef struct packed {
		logic              scan;
		logic              group_mode_select;
		logic [CHAN_W-1:0] chan;
	} asc_ctrl_s;

	localparam asc_ctrl_s CTRL_RST = '{scan: 1'b0, group_mode_select: 1'b0, chan: 4'h0};
endpackage

// ==== rtl/asc_sar.sv ====
// Purpose: One successive-approximation conversion of fixed length.
// Assumes: The comparator is synchronous to the bus clock and settles in a cycle.
// Notes:   A hold sends the conversion back to its sample phase.
`timescale 1ns/1ps
module asc_sar #(
	parameter int W = asc_pkg::RES_W
) (
	input  wire logic         i_core_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_ce,
	input  wire logic         i_start,
	input  wire logic         i_hold,
	input  wire logic         i_cmp_hi,
	output logic              o_sample,
	output logic [W-1:0]      o_dac,
	output logic              o_done
);
	import asc_pkg::*;

	logic             busy_r;
	logic             busy_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic [W-1:0]     sar_r;
	logic [W-1:0]     sar_nxt;
	logic             sample_r;
	logic             sample_nxt;

	if (W < 1 || SAMPLE_CYCLES + W * BIT_CYCLES > CONV_CYCLES) begin : g_bad_w
		$error("asc_sar: conversion does not fit its cycle budget");
	end

	assign o_done = busy_r && cnt_r == CNT_W'(CONV_CYCLES - 1) && !i_hold;

	always_comb begin
		int phase;
		int pos;
		phase = int'(cnt_r) - SAMPLE_CYCLES;
		pos = W - 1 - phase / BIT_CYCLES;
		busy_nxt = busy_r;
		cnt_nxt = cnt_r;
		sar_nxt = sar_r;
		if (i_start) begin
			busy_nxt = 1'b1;
			cnt_nxt = '0;
			sar_nxt = '0;
		end else if (busy_r && i_hold) begin
			// Resampling on resume keeps a stale held charge out of the result.
			cnt_nxt = '0;
			sar_nxt = '0;
		end else if (busy_r) begin
			if (phase >= 0 && phase < W * BIT_CYCLES) begin
				if (phase % BIT_CYCLES == 0) begin
					sar_nxt[pos] = 1'b1;
				end else if (!i_cmp_hi) begin
					sar_nxt[pos] = 1'b0;
				end
			end
			if (o_done) begin
				busy_nxt = 1'b0;
			end else begin
				cnt_nxt = cnt_r + CNT_W'(1);
			end
		end
		sample_nxt = busy_nxt && cnt_nxt < CNT_W'(SAMPLE_CYCLES);
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy_r <= 1'b0;
			cnt_r <= '0;
			sar_r <= '0;
			sample_r <= 1'b0;
		end else if (i_ce) begin
			busy_r <= busy_nxt;
			cnt_r <= cnt_nxt;
			sar_r <= sar_nxt;
			sample_r <= sample_nxt;
		end
	end

	assign o_sample = sample_r;
	assign o_dac = sar_r;

	a_start_sample: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_start && i_ce |=> o_sample && o_dac == '0)
		else $error("conversion did not open with a cleared sample phase");
	a_msb_trial: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		busy_r && i_ce && !i_hold && !i_start && cnt_r == CNT_W'(SAMPLE_CYCLES)
		|=> !o_sample && o_dac == {1'b1, {(W-1){1'b0}}})
		else $error("first trial after sampling is not the top bit alone");
	a_hold_resample: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		busy_r && i_hold && i_ce && !i_start |=> o_sample && cnt_r == '0 && !o_done)
		else $error("hold did not return the conversion to sampling");
endmodule // asc_sar

// ==== tb/asc_seq_ctrl_bench.sv ====
// Purpose: Self-checking bench for the four-conversion sequencer and its registers.
// Assumes: Comparator is modelled as an ideal analog level per channel code.
// Notes:   Each scenario is one task; the register bus is driven as an AXI4-Lite master.
`timescale 1ns/1ps
module asc_seq_ctrl_bench;
	import asc_pkg::*;
	logic         i_core_clk;
	logic         i_rst_n;
	logic         i_stop;
	logic         i_wait;
	logic         i_cmp_hi;
	asc_axi_req_s axi;
	asc_axi_rsp_s rsp;
	asc_ana_s     ana;
	logic [7:0]   ofs;
	logic [7:0]   first_dac;
	logic         prev_s;
	logic         armed;
	int           n_errors;
	int           checked;
	int           cyc;
	int           n_rise;
	int           rise0;
	int           gap;
	int           n_rsv;

	asc_seq_ctrl DUT (
		.i_core_clk(i_core_clk),
		.i_rst_n   (i_rst_n),
		.i_ce      (1'b1),
		.i_axi     (axi),
		.o_axi     (rsp),
		.i_stop    (i_stop),
		.i_wait    (i_wait),
		.i_cmp_hi  (i_cmp_hi),
		.o_ana     (ana)
	);

	always #50 i_core_clk = ~i_core_clk;

	function automatic logic [7:0] tgt(input logic [3:0] ch);
		return {ch, ~ch} ^ ofs;
	endfunction

	function automatic logic [3:0] exp_ch(input logic [7:0] c, input int i);
		return c[BIT_GROUP_MODE_SELECT] ? {c[3:2], i[1:0]} : c[3:0];
	endfunction

	// The comparator is analog, so it follows the trial word within the same cycle.
	always @* begin
		i_cmp_hi = (({ana.mux_sel, ~ana.mux_sel} ^ ofs) >= ana.dac);
	end

	// Watches the sample switch and the first trial word of each conversion.
	always @(posedge i_core_clk) begin
		cyc++;
		if (ana.sample === 1'b1 && prev_s !== 1'b1) begin
			n_rise++;
			if (n_rise == 1)
				rise0 = cyc;
			if (n_rise == 2)
				gap = cyc - rise0;
		end
		if (ana.sample === 1'b1 && ana.mux_ok !== 1'b1)
			n_rsv++;
		prev_s = ana.sample;
		if (ana.sample === 1'b1)
			armed = 1'b1;
		else if (armed && ana.dac !== 8'h00) begin
			first_dac = ana.dac;
			armed = 1'b0;
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	task automatic finish_test;
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
			output logic [1:0] r);
		int  t;
		bit  aw_ok;
		bit  w_ok;
		t = 0;
		aw_ok = 0;
		w_ok = 0;
		r = 2'h3;
		@(posedge i_core_clk);
		axi.awvalid <= 1'b1;
		axi.awaddr  <= a;
		axi.wvalid  <= 1'b1;
		axi.wdata   <= d;
		axi.wstrb   <= s;
		axi.bready  <= 1'b1;
		while (t < 100) begin
			@(posedge i_core_clk);
			t++;
			if (!aw_ok && rsp.awready === 1'b1) begin
				aw_ok = 1;
				axi.awvalid <= 1'b0;
			end
			if (!w_ok && rsp.wready === 1'b1) begin
				w_ok = 1;
				axi.wvalid <= 1'b0;
			end
			if (rsp.bvalid === 1'b1) begin
				r = rsp.bresp;
				axi.bready <= 1'b0;
				break;
			end
		end
		if (t >= 100)
			check(0, 1, "write response timeout");
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int t;
		t = 0;
		@(posedge i_core_clk);
		axi.arvalid <= 1'b1;
		axi.araddr  <= a;
		axi.rready  <= 1'b1;
		while (t < 100) begin
			@(posedge i_core_clk);
			t++;
			if (rsp.arready === 1'b1)
				axi.arvalid <= 1'b0;
			if (rsp.rvalid === 1'b1) begin
				d = rsp.rdata;
				r = rsp.rresp;
				axi.rready <= 1'b0;
				break;
			end
		end
		if (t >= 100)
			check(0, 1, "read response timeout");
	endtask

	task automatic wait_done;
		logic [31:0] d;
		logic [1:0]  r;
		int          n;
		n = 0;
		do begin
			rd(OFS_CTRL, d, r);
			n++;
		end while (d[BIT_FLAG] !== 1'b1 && n < 300);
		check({31'h0, d[BIT_FLAG]}, 32'h1, "done flag");
	endtask

	task automatic check_slots(input logic [7:0] code, input bit skip_rsv);
		logic [31:0] d;
		logic [1:0]  r;
		logic [3:0]  ch;
		for (int i = 0; i < SLOTS; i++) begin
			ch = exp_ch(code, i);
			// A reserved code leaves its slot undefined, so only defined codes are compared.
			if (!(skip_rsv && (ch[3:2] == CODE_RSV_GRP || ch == CODE_RSV_TOP))) begin
				rd(OFS_SLOT1 + 8'(4 * i), d, r);
				check(d, {24'h0, tgt(ch)}, "slot result");
			end
		end
	endtask

	task automatic t_reset;
		logic [31:0] d;
		logic [1:0]  r;
		rd(OFS_CTRL, d, r);
		check(d, 32'h0, "control after reset");
		rd(OFS_SLOT4, d, r);
		check(d, 32'h0, "slot after reset");
		rd(8'h14, d, r);
		check({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
	endtask

	task automatic t_single;
		logic [31:0] d;
		logic [1:0]  r;
		n_rise = 0;
		wr(OFS_CTRL, 32'hc3, 4'h1, r);
		wait_done();
		rd(OFS_CTRL, d, r);
		check(d, 32'h83, "status read back with bit six low");
		check_slots(8'h03, 0);
		check(32'(gap), 32'(CONV_CYCLES), "conversion spacing");
		check({24'h0, first_dac}, 32'h80, "first trial word");
		repeat (200) @(posedge i_core_clk);
		check(32'(n_rise), 32'd4, "conversions per one-shot sequence");
	endtask

	// The rsv argument says whether the selected group holds any reserved code.
	task automatic t_group(input logic [7:0] code, input bit rsv);
		logic [1:0] r;
		n_rsv = 0;
		wr(OFS_CTRL, {24'h0, code}, 4'h1, r);
		wait_done();
		check(32'(n_rsv != 0), 32'(rsv), "reserved channel marking");
		check_slots(code, 1);
	endtask

	task automatic t_hold;
		logic [1:0] r;
		n_rise = 0;
		wr(OFS_CTRL, 32'h10, 4'h1, r);
		repeat (20) @(posedge i_core_clk);
		i_stop <= 1'b1;
		repeat (10) @(posedge i_core_clk);
		// This stop exit stands for one with the startup delay enabled, so the
		// settled comparator needs no extra wait before results are trusted.
		i_stop <= 1'b0;
		repeat (50) @(posedge i_core_clk);
		i_wait <= 1'b1;
		repeat (5) @(posedge i_core_clk);
		i_wait <= 1'b0;
		wait_done();
		check_slots(8'h10, 0);
		check(32'(n_rise), 32'd6, "resampled conversions");
	endtask

	task automatic t_refuse;
		logic [31:0] d;
		logic [31:0] v0;
		logic [1:0]  r;
		rd(OFS_CTRL, v0, r);
		n_rise = 0;
		wr(8'h08, 32'hff, 4'h1, r);
		check({30'h0, r}, {30'h0, RESP_OKAY}, "slot write response");
		rd(8'h08, d, r);
		check(d, {24'h0, tgt(4'h1)}, "slot unchanged by write");
		wr(OFS_CTRL, 32'h3f, 4'h0, r);
		repeat (40) @(posedge i_core_clk);
		rd(OFS_CTRL, d, r);
		check(d, v0, "control without lane zero");
		check(32'(n_rise), 32'd0, "no sequence without lane zero");
		wr(8'h14, 32'h1, 4'h1, r);
		check({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
	endtask

	task automatic t_abort;
		logic [31:0] d;
		logic [1:0]  r;
		wr(OFS_CTRL, 32'h00, 4'h1, r);
		wait_done();
		wr(OFS_CTRL, 32'h02, 4'h1, r);
		rd(OFS_CTRL, d, r);
		check(d, 32'h02, "flag cleared by write");
		repeat (40) @(posedge i_core_clk);
		n_rise = 0;
		wr(OFS_CTRL, 32'h07, 4'h1, r);
		wait_done();
		check_slots(8'h07, 0);
		check(32'(n_rise), 32'd4, "fresh sequence length");
	endtask

	task automatic t_scan(input logic [7:0] code);
		logic [31:0] d;
		logic [1:0]  r;
		ofs <= 8'h00;
		wr(OFS_CTRL, {24'h0, code}, 4'h1, r);
		wait_done();
		ofs <= 8'h33;
		repeat (300) @(posedge i_core_clk);
		rd(OFS_CTRL, d, r);
		check(d, {24'h0, 8'h80 | code}, "flag stays set while repeating");
		check_slots(code, 0);
	endtask

	initial begin
		i_core_clk = 1'b0;
		i_rst_n = 1'b0;
		i_stop = 1'b0;
		i_wait = 1'b0;
		axi = '0;
		ofs = 8'h00;
		prev_s = 1'b0;
		armed = 1'b0;
		first_dac = 8'h00;
		repeat (16) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		t_reset();
		t_single();
		t_group(8'h15, 0);
		t_group(8'h1e, 1);
		t_group(8'h19, 1);
		t_hold();
		t_refuse();
		t_abort();
		t_scan(8'h21);
		t_scan(8'h35);
		finish_test();
	end

	// Whole run needs well under ten thousand cycles.
	initial begin
		repeat (20000) @(posedge i_core_clk);
		n_errors++;
		finish_test();
	end
endmodule // asc_seq_ctrl_bench
